/* File: src/pd_src_consts.vh */
// Constants for the source policy engine: register map, fields, timing and limits.
`ifndef PD_SRC_CONSTS_VH
`define PD_SRC_CONSTS_VH

// Clock rate in hertz and in cycles per microsecond.
`define PD_CLK_HZ          40000000
`define PD_CYC_PER_US      (`PD_CLK_HZ / 1000000)

// Timer periods in microseconds (plain defaults).
`define PD_T_SRC_CAP_US    150000
`define PD_T_SEND_RESP_US  27000
`define PD_T_NO_RESP_US    5000000
`define PD_T_SWAP_START_US 20000

// Retry limits (plain defaults).
`define PD_N_CAPS          50
`define PD_N_HARD_RESET    2

// Register byte offsets.
`define PD_REG_CTRL        4'h0
`define PD_REG_STATUS      4'h4
`define PD_REG_CAPS        4'h8

// Control register fields.
`define PD_CTRL_TYPE_C     0
`define PD_CTRL_INS_DET    1
`define PD_CTRL_OPT_DIS    2
`define PD_CTRL_UNRESP_DIS 3
`define PD_CTRL_HR_REQ     4
`define PD_CTRL_SWAP       5
`define PD_CTRL_RESET      32'h0000_0000

// Status register fields.
`define PD_ST_STATE_LSB    0
`define PD_ST_PD_CONN      8
`define PD_ST_ATTACH_PD    9
`define PD_ST_PLUG         10
`define PD_ST_CAPS_LSB     16
`define PD_ST_HR_LSB       24

// Capabilities word reset value.
`define PD_CAPS_RESET      32'h0000_0000

`endif

/* File: src/pd_sync2.v */
// Two-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module pd_sync2 (
    // Clock and reset.
    input  wire clk_i,
    input  wire rst_b_i,
    // Asynchronous level in, synchronised level out.
    input  wire d_i,
    output reg  q_o
);
    reg meta_r; // First stage, read only by the second stage.

    // Two stages; the first flop feeds nothing but the second.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

/* File: src/pd_tmr.v */
// Down-counting one-shot timer with a sticky expiry level.
`timescale 1ns/1ps
module pd_tmr #(
    parameter W   = 32,
    parameter CNT = 1000
) (
    // Clock and reset.
    input  wire clk_i,
    input  wire rst_b_i,
    // Load and run, or stop and clear.
    input  wire load_i,
    input  wire stop_i,
    // Expiry level, high from timeout until the next load or stop.
    output reg  done_o
);
    reg [W-1:0] cnt_r; // Cycles left.
    reg         run_r; // Timer is counting.

    // Load wins over stop; expiry stays set until the owner clears it.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_r  <= {W{1'b0}};
            run_r  <= 1'b0;
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_r  <= CNT[W-1:0] - {{(W-1){1'b0}}, 1'b1};
            run_r  <= 1'b1;
            done_o <= 1'b0;
        end else if (stop_i) begin
            run_r  <= 1'b0;
            done_o <= 1'b0;
        end else if (run_r) begin
            if (cnt_r == {W{1'b0}}) begin
                run_r  <= 1'b0;
                done_o <= 1'b1;
            end else begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

/* File: src/pd_src_pe.v */
// Source policy engine: startup, discovery, send-capabilities, disabled, error paths.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`include "pd_src_consts.vh"
`timescale 1ns/1ps
//
// Function
// - Start in startup after power-up or hard reset.
// - Startup entry clears caps count, resets protocol.
// - Protocol reset clears message ID state.
// - First start: go send caps after reset.
// - After swap: wait swap timer first.
// - Insertion detect: hold startup until plug attached.
// - Discovery entry loads the source capability timer.
// - Capability timeout, count within limit: send caps.
// - Optionally disable when limit exceeded, unconnected.
// - No response, limit exceeded, never connected: disable.
// - Disabled acts unattached until detach and reattach.
// - Previously connected Type-C port: error recovery.
// - Send caps entry: fetch, transmit, count up.
// - GoodCRC: stop no-response, clear counters, start response.
// - Hard reset count cleared only here, power-up.
// - Request received: go negotiate capability.
// - Send failed, not connected: back to discovery.
// - Response timeout: go to hard reset.
// - Unresponsive sink: go discovery or disabled.
// - State timers run only inside their state.
// - Protocol first, then timeouts, then hard reset requests; swap requests win.
// - No response within limit, or request: hard reset.
module pd_src_pe #(
    parameter CAPS_W       = 6,
    parameter HR_W         = 4,
    parameter N_CAPS       = `PD_N_CAPS,
    parameter N_HR         = `PD_N_HARD_RESET,
    parameter SRC_CAP_CYC  = `PD_T_SRC_CAP_US * `PD_CYC_PER_US,
    parameter SEND_RSP_CYC = `PD_T_SEND_RESP_US * `PD_CYC_PER_US,
    parameter NO_RSP_CYC   = `PD_T_NO_RESP_US * `PD_CYC_PER_US,
    parameter SWAP_CYC     = `PD_T_SWAP_START_US * `PD_CYC_PER_US
) (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Avalon-MM register slave.
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Protocol layer indications, same clock.
    input  wire        prl_reset_done_i,
    input  wire        tx_goodcrc_i,
    input  wire        tx_fail_i,
    input  wire        rx_request_i,
    input  wire        hard_reset_done_i,
    // Plug attach pin, asynchronous.
    input  wire        plug_attached_i,
    // Protocol layer requests and state view.
    output reg         prl_reset_o,
    output reg         tx_caps_o,
    output reg  [31:0] tx_caps_data_o,
    output reg         hard_reset_o,
    output reg         err_recovery_o,
    output reg  [2:0]  state_o
);
    // Engine states.
    localparam [2:0] ST_STARTUP   = 3'd0;
    localparam [2:0] ST_DISCOVERY = 3'd1;
    localparam [2:0] ST_SEND_CAPS = 3'd2;
    localparam [2:0] ST_DISABLED  = 3'd3;
    localparam [2:0] ST_NEGOTIATE = 3'd4;
    localparam [2:0] ST_HARD_RST  = 3'd5;
    localparam [2:0] ST_ERR_REC   = 3'd6;

    // Register file.
    reg  [31:0]       ctrl_r;      // Control bits, pulse bits read back as zero.
    reg  [31:0]       caps_r;      // Capabilities word handed to the protocol layer.
    reg               hr_req_r;    // One-cycle hard reset request from software.
    reg               swap_req_r;  // One-cycle power role swap restart from software.
    // Engine state.
    reg  [2:0]        state_r;     // Present state.
    reg  [2:0]        state_nxt;   // Next state.
    reg               swap_entry_r;// Startup was entered after a role swap.
    reg               prl_done_r;  // Protocol reset completed since startup entry.
    reg               pd_conn_r;   // Partners presently PD connected.
    reg               attach_pd_r; // PD connected at some time in this attachment.
    reg               detached_r;  // Detach seen while disabled or in recovery.
    reg  [CAPS_W-1:0] caps_cnt_r;  // Capabilities messages sent.
    reg  [HR_W-1:0]   hr_cnt_r;    // Hard resets issued.
    reg               nr_stop;     // Stop the no-response timer this cycle.
    wire              plug_s;      // Synchronised plug level.
    wire              cap_done;    // Source capability timer expired.
    wire              rsp_done;    // Sender response timer expired.
    wire              nr_done;     // No-response timer expired.
    wire              swp_done;    // Swap start timer expired.
    wire              restart;     // Outside event that re-enters startup.
    wire              enter;       // A state is being entered this cycle.
    wire              wr_go;       // Bus write takes effect this edge.
    wire              hr_over;     // Hard reset count beyond its limit.
    wire              caps_over;   // Capabilities count beyond its limit.
    wire              type_c;      // Port is Type-C.

    assign type_c    = ctrl_r[`PD_CTRL_TYPE_C];
    assign hr_over   = hr_cnt_r > N_HR;
    assign caps_over = caps_cnt_r > N_CAPS;
    assign restart   = hard_reset_done_i | swap_req_r;
    assign enter     = (state_nxt != state_r) | restart;
    assign wr_go     = avs_write_i & ~avs_waitrequest_o;

    // Synchronise the plug pin before any logic reads it.
    pd_sync2 u_plug_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (plug_attached_i),
        .q_o     (plug_s)
    );

    // Capability timer lives only in discovery.
    pd_tmr #(.W(32), .CNT(SRC_CAP_CYC)) u_cap_tmr (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (enter & (state_nxt == ST_DISCOVERY)),
        .stop_i  (state_nxt != ST_DISCOVERY),
        .done_o  (cap_done)
    );

    // Response timer lives only in send-capabilities, started by GoodCRC.
    pd_tmr #(.W(32), .CNT(SEND_RSP_CYC)) u_rsp_tmr (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  ((state_r == ST_SEND_CAPS) & tx_goodcrc_i & ~enter),
        .stop_i  (state_nxt != ST_SEND_CAPS),
        .done_o  (rsp_done)
    );

    // No-response timer spans states; started when a hard reset completes.
    pd_tmr #(.W(32), .CNT(NO_RSP_CYC)) u_nr_tmr (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (hard_reset_done_i),
        .stop_i  (nr_stop),
        .done_o  (nr_done)
    );

    // Swap timer lives only in startup entered after a role swap.
    pd_tmr #(.W(32), .CNT(SWAP_CYC)) u_swp_tmr (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (swap_req_r),
        .stop_i  (state_nxt != ST_STARTUP),
        .done_o  (swp_done)
    );

    // Next state; within each state protocol events are tested first,
    // then timeouts, then hard reset requests; a role swap request wins over all.
    always @* begin
        state_nxt = state_r;
        nr_stop   = 1'b0;
        case (state_r)
            ST_STARTUP: begin
                // Hold while no plug is seen on an insertion detect port.
                if (ctrl_r[`PD_CTRL_INS_DET] & ~plug_s) begin
                    state_nxt = ST_STARTUP;
                end else if (swap_entry_r) begin
                    if (swp_done) begin
                        state_nxt = ST_SEND_CAPS;
                    end
                end else if (prl_done_r) begin
                    state_nxt = ST_SEND_CAPS;
                end
            end
            ST_DISCOVERY: begin
                if (cap_done & ~caps_over) begin
                    state_nxt = ST_SEND_CAPS;
                end else if (nr_done & hr_over & type_c & attach_pd_r) begin
                    state_nxt = ST_ERR_REC;
                end else if (nr_done & hr_over) begin
                    state_nxt = ST_DISABLED;
                end else if (cap_done & ~pd_conn_r & ctrl_r[`PD_CTRL_OPT_DIS]) begin
                    state_nxt = ST_DISABLED;
                end
            end
            ST_SEND_CAPS: begin
                if (rx_request_i) begin
                    state_nxt = ST_NEGOTIATE;
                end else if (tx_goodcrc_i) begin
                    nr_stop = 1'b1;
                end else if (tx_fail_i & ~pd_conn_r) begin
                    state_nxt = ST_DISCOVERY;
                end else if (rsp_done) begin
                    state_nxt = ST_HARD_RST;
                end else if (nr_done & hr_over & type_c & attach_pd_r) begin
                    state_nxt = ST_ERR_REC;
                end else if (nr_done & hr_over) begin
                    nr_stop   = 1'b1;
                    state_nxt = ctrl_r[`PD_CTRL_UNRESP_DIS] ? ST_DISABLED : ST_DISCOVERY;
                end
            end
            ST_DISABLED, ST_ERR_REC: begin
                // Unattached behaviour until a detach and a reattach are seen.
                if (detached_r & plug_s) begin
                    state_nxt = ST_STARTUP;
                end
            end
            ST_NEGOTIATE, ST_HARD_RST: begin
                state_nxt = state_r;
            end
            default: begin
                state_nxt = ST_STARTUP;
            end
        endcase
        // Hard reset from most states; protocol and timer exits above win.
        if ((state_nxt == state_r) & (state_r != ST_HARD_RST) & (state_r != ST_DISABLED)
            & (state_r != ST_ERR_REC)) begin
            if ((nr_done & ~hr_over) | hr_req_r) begin
                state_nxt = ST_HARD_RST;
            end
        end
        // Hard reset completion or a role swap restarts the engine.
        if (restart) begin
            state_nxt = ST_STARTUP;
        end
    end

    // State register, entry actions and counters.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r        <= ST_STARTUP;
            swap_entry_r   <= 1'b0;
            prl_done_r     <= 1'b0;
            pd_conn_r      <= 1'b0;
            attach_pd_r    <= 1'b0;
            detached_r     <= 1'b0;
            caps_cnt_r     <= {CAPS_W{1'b0}};
            hr_cnt_r       <= {HR_W{1'b0}};
            prl_reset_o    <= 1'b1;
            tx_caps_o      <= 1'b0;
            tx_caps_data_o <= `PD_CAPS_RESET;
            hard_reset_o   <= 1'b0;
            err_recovery_o <= 1'b0;
            state_o        <= ST_STARTUP;
        end else begin
            state_r        <= state_nxt;
            state_o        <= state_nxt;
            prl_reset_o    <= 1'b0;
            tx_caps_o      <= 1'b0;
            hard_reset_o   <= 1'b0;
            err_recovery_o <= 1'b0;
            // Protocol reset completion is remembered until startup is next entered.
            if (enter & (state_nxt == ST_STARTUP)) begin
                prl_done_r <= 1'b0;
            end else if (prl_reset_done_i) begin
                prl_done_r <= 1'b1;
            end
            // Startup entry: clear the capabilities count, reset protocol layer.
            if (enter & (state_nxt == ST_STARTUP)) begin
                caps_cnt_r   <= {CAPS_W{1'b0}};
                prl_reset_o  <= 1'b1;
                swap_entry_r <= swap_req_r;
            end
            // Send-capabilities entry: latch, transmit and count.
            if (enter & (state_nxt == ST_SEND_CAPS)) begin
                tx_caps_data_o <= caps_r;
                tx_caps_o      <= 1'b1;
                if (~&caps_cnt_r) begin
                    caps_cnt_r <= caps_cnt_r + {{(CAPS_W-1){1'b0}}, 1'b1};
                end
            end
            // Acknowledged capabilities: connected, counters back to zero.
            if ((state_r == ST_SEND_CAPS) & tx_goodcrc_i & ~enter) begin
                caps_cnt_r  <= {CAPS_W{1'b0}};
                hr_cnt_r    <= {HR_W{1'b0}};
                pd_conn_r   <= 1'b1;
                attach_pd_r <= 1'b1;
            end
            // Hard reset entry: signal it, count it, drop the connection.
            if (enter & (state_nxt == ST_HARD_RST)) begin
                hard_reset_o <= 1'b1;
                pd_conn_r    <= 1'b0;
                if (~&hr_cnt_r) begin
                    hr_cnt_r <= hr_cnt_r + {{(HR_W-1){1'b0}}, 1'b1};
                end
            end
            if (enter & (state_nxt == ST_ERR_REC)) begin
                err_recovery_o <= 1'b1;
            end
            // Detach tracking for the unattached states.
            if (enter & ((state_nxt == ST_DISABLED) | (state_nxt == ST_ERR_REC))) begin
                detached_r <= 1'b0;
            end else if (~plug_s) begin
                detached_r  <= 1'b1;
                attach_pd_r <= 1'b0;
                pd_conn_r   <= 1'b0;
            end
        end
    end

    // Readback value for a register offset.
    function [31:0] rd_mux;
        input [3:0] addr;
        begin
            case (addr)
                `PD_REG_CTRL:   rd_mux = ctrl_r;
                `PD_REG_CAPS:   rd_mux = caps_r;
                `PD_REG_STATUS: begin
                    rd_mux = 32'h0000_0000;
                    rd_mux[`PD_ST_STATE_LSB +: 3]     = state_r;
                    rd_mux[`PD_ST_PD_CONN]            = pd_conn_r;
                    rd_mux[`PD_ST_ATTACH_PD]          = attach_pd_r;
                    rd_mux[`PD_ST_PLUG]               = plug_s;
                    rd_mux[`PD_ST_CAPS_LSB +: CAPS_W] = caps_cnt_r;
                    rd_mux[`PD_ST_HR_LSB +: HR_W]     = hr_cnt_r;
                end
                default:        rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // Byte-lane merge of a write into an old word.
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer      i;
        begin
            be_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    be_merge[i*8 +: 8] = wd[i*8 +: 8];
                end
            end
        end
    endfunction

    // Avalon slave: one wait cycle, then the access completes.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_r            <= `PD_CTRL_RESET;
            caps_r            <= `PD_CAPS_RESET;
            hr_req_r          <= 1'b0;
            swap_req_r        <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            hr_req_r   <= 1'b0;
            swap_req_r <= 1'b0;
            if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
                // First cycle of a request: answer on the next edge.
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o    <= avs_read_i ? rd_mux(avs_address_i) : 32'h0000_0000;
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
            if (wr_go & (avs_address_i == `PD_REG_CTRL)) begin
                ctrl_r <= be_merge(ctrl_r, avs_writedata_i, avs_byteenable_i)
                          & 32'h0000_000F;
                if (avs_byteenable_i[0]) begin
                    hr_req_r   <= avs_writedata_i[`PD_CTRL_HR_REQ];
                    swap_req_r <= avs_writedata_i[`PD_CTRL_SWAP];
                end
            end
            if (wr_go & (avs_address_i == `PD_REG_CAPS)) begin
                caps_r <= be_merge(caps_r, avs_writedata_i, avs_byteenable_i);
            end
        end
    end
endmodule

/* File: verif/pd_prl_model.sv */
// Protocol layer stand-in for the source policy engine.
`timescale 1ns/1ps
module pd_prl_model (
    // Clock and reset.
    input  wire       clk_i,
    input  wire       rst_b_i,
    // Requests from the policy engine.
    input  wire       prl_rst_i,
    input  wire       caps_i,
    input  wire       hrst_i,
    // Answer: 0 GoodCRC, 1 send fails, 2 none; request delay, 0 is none.
    input  wire [1:0] ack_mode_i,
    input  wire [7:0] req_dly_i,
    // Indications back to the engine.
    output logic      rst_done_o,
    output logic      goodcrc_o,
    output logic      fail_o,
    output logic      request_o,
    output logic      hr_done_o
);
    logic [7:0] rst_c_r;  // To reset done.
    logic [7:0] tx_c_r;   // To send outcome.
    logic [7:0] req_c_r;  // To sink request.
    logic [7:0] hr_c_r;   // To hard reset done.
    // A request arms a countdown; the answer pulses when it reaches one.
    always @(posedge clk_i) begin
        rst_done_o <= (rst_c_r == 8'd1);
        goodcrc_o  <= (tx_c_r == 8'd1) && (ack_mode_i == 2'd0);
        fail_o     <= (tx_c_r == 8'd1) && (ack_mode_i == 2'd1);
        request_o  <= (req_c_r == 8'd1);
        hr_done_o  <= (hr_c_r == 8'd1);
        rst_c_r    <= prl_rst_i ? 8'd3 : rst_c_r - {7'h0, |rst_c_r};
        tx_c_r     <= caps_i ? 8'd2 : tx_c_r - {7'h0, |tx_c_r};
        hr_c_r     <= hrst_i ? 8'd5 : hr_c_r - {7'h0, |hr_c_r};
        // The sink asks only after an acknowledged send.
        if (tx_c_r == 8'd1 && ack_mode_i == 2'd0) begin
            req_c_r <= req_dly_i;
        end else begin
            req_c_r <= req_c_r - {7'h0, |req_c_r};
        end
        if (!rst_b_i) begin
            tx_c_r  <= 8'h00;
            req_c_r <= 8'h00;
            hr_c_r  <= 8'h00;
        end
    end
endmodule

/* File: verif/pd_src_pe_assertions.sv */
// Port checks for the source policy engine.
`timescale 1ns/1ps
module pd_src_pe_assertions (
    // Clock and reset.
    input wire       clk_i,
    input wire       rst_b_i,
    // Bus and protocol inputs.
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    input wire       tx_goodcrc_i,
    input wire       rx_request_i,
    input wire       hard_reset_done_i,
    // Engine outputs.
    input wire       prl_reset_o,
    input wire       tx_caps_o,
    input wire       hard_reset_o,
    input wire       err_recovery_o,
    input wire [2:0] state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // State arrivals.
    sequence s_to_start;
        state_o != 3'd0 ##1 state_o == 3'd0;
    endsequence
    sequence s_to_disc;
        state_o == 3'd2 ##1 state_o == 3'd1;
    endsequence
    sequence s_to_caps;
        state_o != 3'd2 ##1 state_o == 3'd2;
    endsequence
    AST_START_RESETS_PRL: assert property (s_to_start |-> prl_reset_o)
        else $error("startup entry without reset");
    AST_CAPS_ENTRY_SENDS: assert property (s_to_caps |-> tx_caps_o)
        else $error("send entry without send");
    AST_CAPS_ONLY_ON_ENTRY: assert property
        (tx_caps_o |-> state_o == 3'd2 && $past(state_o) != 3'd2)
        else $error("send outside send entry");
    AST_HARD_RESET_ENTRY: assert property
        (hard_reset_o |-> state_o == 3'd5 && $past(state_o) != 3'd5)
        else $error("hard reset pulse off entry");
    AST_ERR_ENTRY: assert property
        (err_recovery_o |-> state_o == 3'd6 && $past(state_o) != 3'd6)
        else $error("recovery pulse off entry");
    AST_REQUEST_NEGOTIATES: assert property
        (state_o == 3'd2 && rx_request_i && !hard_reset_done_i |=> state_o == 3'd4)
        else $error("request not negotiated");
    AST_RESTART_ON_HR_DONE: assert property
        (hard_reset_done_i |=> state_o == 3'd0 && prl_reset_o)
        else $error("no restart after hard reset");
    AST_DISC_TIMER_HOLDS: assert property (s_to_disc |-> (state_o == 3'd1) [*8])
        else $error("discovery left early");
    AST_RESP_TIMER_BOUND: assert property
        (state_o == 3'd2 && tx_goodcrc_i |-> ##[1:80] state_o != 3'd2)
        else $error("send state not left in time");
    AST_BUS_ONE_WAIT: assert property
        ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
         avs_waitrequest_o)
        else $error("bus answer not after one wait");
endmodule
bind pd_src_pe pd_src_pe_assertions pd_src_pe_assertions_i (.*);

/* File: verif/tb_pd_src_pe.sv */
// Bench for the source policy engine.
`include "pd_src_consts.vh"
`timescale 1ns/1ps
module tb_pd_src_pe;
    logic        clk_i, rst_b_i, avs_read_i, avs_write_i, plug_attached_i;
    logic [3:0]  avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, rd;
    wire  [31:0] avs_readdata_o, tx_caps_data_o;
    wire         avs_waitrequest_o, prl_reset_o, tx_caps_o, hard_reset_o, err_recovery_o;
    wire         prl_reset_done_i, tx_goodcrc_i, tx_fail_i, rx_request_i, hard_reset_done_i;
    wire  [2:0]  state_o;
    logic [1:0]  ack_mode;   // Model answer kind.
    logic [7:0]  req_dly;    // Model request delay.
    int          num_errors, n_checks;
    // Short timers keep the run brief.
    pd_src_pe #(.N_CAPS(3), .N_HR(2), .SRC_CAP_CYC(40), .SEND_RSP_CYC(60),
                .NO_RSP_CYC(1000), .SWAP_CYC(20)) pd_src_pe_i (.*);
    pd_prl_model pd_prl_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .prl_rst_i(prl_reset_o),
        .caps_i(tx_caps_o), .hrst_i(hard_reset_o), .ack_mode_i(ack_mode), .req_dly_i(req_dly),
        .rst_done_o(prl_reset_done_i), .goodcrc_o(tx_goodcrc_i), .fail_o(tx_fail_i),
        .request_o(rx_request_i), .hr_done_o(hard_reset_done_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
        chk("bus answer", 0, n > 99 || avs_waitrequest_o !== 1'b1);
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (state_o !== s && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk("state", s, state_o);
    endtask
    task automatic hold_st(input logic [2:0] s, input int cyc);
        repeat (cyc) begin
            @(posedge clk_i);
            chk("held state", s, state_o);
        end
    endtask
    task automatic t_startup();
        wait_st(3'd2, 20);
        wait_st(3'd4, 30);
        bus(0, `PD_REG_STATUS, 0);
        chk("caps count", 0, rd[21:16]);
        bus(0, 4'hC, 0);
        chk("unmapped read", 0, rd);
        avs_byteenable_i <= 4'hE;
        bus(1, `PD_REG_CTRL, 32'hFFFF_FFFF);
        avs_byteenable_i <= 4'hF;
        bus(0, `PD_REG_STATUS, 0);
        chk("status state", 4, rd[2:0]);
    endtask
    task automatic t_swap();
        bus(1, `PD_REG_CAPS, 32'hA5C3_1E0F);
        req_dly <= 8'h00;
        bus(1, `PD_REG_CTRL, 32'h0000_0020);
        wait_st(3'd0, 5);
        hold_st(3'd0, 12);
        wait_st(3'd2, 30);
        chk("caps data", 32'hA5C3_1E0F, tx_caps_data_o);
        hold_st(3'd2, 50);
        ack_mode <= 2'd1;
        wait_st(3'd5, 30);
        wait_st(3'd0, 20);
        bus(0, `PD_REG_STATUS, 0);
        chk("hr count", 1, rd[27:24]);
    endtask
    task automatic t_discovery();
        bus(1, `PD_REG_CTRL, 32'h0000_0006);
        wait_st(3'd1, 40);
        hold_st(3'd1, 20);
        wait_st(3'd2, 40);
        wait_st(3'd3, 300);
        bus(0, `PD_REG_STATUS, 0);
        chk("caps count", 4, rd[21:16]);
        plug_attached_i <= 1'b0;
        hold_st(3'd3, 30);
        bus(1, `PD_REG_CTRL, 32'h0000_0026);
        wait_st(3'd0, 5);
        hold_st(3'd0, 40);
        plug_attached_i <= 1'b1;
        wait_st(3'd2, 20);
    endtask
    task automatic t_no_response();
        ack_mode <= 2'd2;
        bus(1, `PD_REG_CTRL, 32'h0000_000A);
        repeat (2) begin
            wait_st(3'd5, 1200);
            wait_st(3'd2, 30);
        end
        wait_st(3'd3, 1200);
        bus(0, `PD_REG_STATUS, 0);
        chk("hr count", 3, rd[27:24]);
    endtask
    task automatic t_err_recovery();
        int n;
        n = 0;
        plug_attached_i <= 1'b0;
        ack_mode <= 2'd0;
        bus(1, `PD_REG_CTRL, 32'h0000_0003);
        plug_attached_i <= 1'b1;
        while (tx_goodcrc_i !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        bus(0, `PD_REG_STATUS, 0);
        chk("hr count", 0, rd[27:24]);
        ack_mode <= 2'd2;
        repeat (3) begin
            wait_st(3'd5, 1200);
            wait_st(3'd2, 30);
        end
        wait_st(3'd6, 1200);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {num_errors, n_checks, avs_read_i, avs_write_i, rst_b_i} = '0;
        {avs_address_i, avs_writedata_i, ack_mode} = '0;
        avs_byteenable_i = 4'hF;
        plug_attached_i = 1'b1;
        req_dly = 8'd5;
        repeat (3) @(posedge clk_i);
        chk("protocol reset", 1, prl_reset_o);
        rst_b_i <= 1'b1;
        t_startup();
        t_swap();
        t_discovery();
        t_no_response();
        t_err_recovery();
        tally_and_finish();
    end
    // A hang counts as a mismatch.
    initial begin
        #(25 * 20000);
        num_errors++;
        tally_and_finish();
    end
endmodule
